// ### verilog/sar_link_defs.svh
/*
 * timing and field constants shared by both ends of the converter link.
 * assumes the system clock period given by CLK_PERIOD_NS.
 */
`ifndef SAR_LINK_DEFS_SVH
`define SAR_LINK_DEFS_SVH

`define CLK_PERIOD_NS        50
`define RESOLUTION_BITS      16
`define CORRECTION_DECISION  10

// bit decision period and the correction step before the tenth decision
`define BIT_TIME_NS          1000
`define CORRECT_TIME_NS      500
`define BIT_CYCLES           ((`BIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CORRECT_CYCLES       ((`CORRECT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// host side timing
`define QUIET_AFTER_START_NS 8000
`define START_LOW_NS         1000
`define START_LOW_CYCLES     ((`START_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_NS              500
`define STEP_CYCLES          ((`STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_NS            1000000
`define SETTLE_CYCLES        ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SHIFT_HALF_CYCLES    4

`endif

// ### verilog/sar_link_pkg.sv
/*
 * state types of the converter end and the host end.
 * assumes nothing of its surroundings.
 */
package sar_link_pkg;

  typedef enum logic [1:0] {
    conversion_start_n_idle    = 2'h0,
    conversion_start_n_decide  = 2'h1,
    conversion_start_n_correct = 2'h2,
    conversion_start_n_asleep  = 2'h3
  } conversion_start_n_state_type;

  typedef enum logic [3:0] {
    host_idle        = 4'h0,
    host_start       = 4'h1,
    host_wait        = 4'h2,
    host_shift_high  = 4'h3,
    host_shift_low   = 4'h4,
    host_sleep_entry = 4'h5,
    host_asleep      = 4'h6,
    host_wake_step   = 4'h7,
    host_settle      = 4'h8
  } host_state_type;

endpackage : sar_link_pkg

// ### verilog/converter_link_if.sv
/*
 * pins between the converter and its host controller.
 * assumes both ends run from their own clocks; every pin is synchronised on entry.
 */
`timescale 1ns/10ps

interface converter_link_if;
  logic conversion_start_n;
  logic power_down_request;
  logic serial_shift_clock_in;
  logic busy_n;
  logic serial_data;

  modport device_end (
    input  conversion_start_n,
    input  power_down_request,
    input  serial_shift_clock_in,
    output busy_n,
    output serial_data
  );

  modport host_end (
    output conversion_start_n,
    output power_down_request,
    output serial_shift_clock_in,
    input  busy_n,
    input  serial_data
  );
endinterface : converter_link_if

// ### verilog/sar_converter_end.sv
/*
 * converter end: power-down control, successive approximation sequencer with
 * correction before the tenth decision, and serial result shifter.
 * assumes an external comparator that answers on the same clock and a host that
 * keeps the link pins static during the quiet window.
 */
// Summary of operation
// - start low then power-down high enters sleep
// - host exits: start high first, then power-down low
// - power-down rising with start low begins conversion
// - sleep disables analog; reference floats while requested
// - host waits settling time after waking
// - sixteen decisions, most significant bit first
// - set trial bit, clear it if too high
// - correction at tenth decision only, none after
// - host keeps inputs static from 8us to end
// - host releases start early, no mid-conversion clocks
// - tenth bit resolved between 10us and 11us
`timescale 1ns/10ps
`include "sar_link_defs.svh"

module sar_converter_end #(
  parameter int RESOLUTION     = `RESOLUTION_BITS,
  parameter int BIT_CYCLES     = `BIT_CYCLES,
  parameter int CORRECT_CYCLES = `CORRECT_CYCLES
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // link to the host
  converter_link_if.device_end       link,
  // analog front end
  input  wire logic                  comparator_high,
  output logic      [RESOLUTION-1:0] trial_value,
  output logic                       analog_enable,
  output logic                       reference_hiz,
  // conversion result
  output logic      [RESOLUTION-1:0] result,
  output logic                       result_valid
);

  localparam int IW = $clog2(RESOLUTION);
  localparam int TW = 8;
  localparam logic [IW-1:0] TOP_INDEX = IW'(RESOLUTION - 1);
  localparam logic [IW-1:0] CORRECT_INDEX = IW'(RESOLUTION - `CORRECTION_DECISION);

  generate
    if (RESOLUTION < `CORRECTION_DECISION || BIT_CYCLES < 1 || CORRECT_CYCLES < 1 ||
        BIT_CYCLES >= (1 << TW) || CORRECT_CYCLES >= (1 << TW)) begin : g_bad_params
      $error("sar_converter_end: unsupported parameter values");
    end
  endgenerate

  function automatic logic [RESOLUTION-1:0] bit_weight(input logic [IW-1:0] idx);
    bit_weight = {{(RESOLUTION-1){1'b0}}, 1'b1} << idx;
  endfunction : bit_weight

  // pin synchronisers: stage one, stage two, and a delayed copy for edges
  logic [2:0] sync_first;
  logic [2:0] sync_second;
  logic [2:0] sync_prev;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_first  <= 3'h1;
      sync_second <= 3'h1;
      sync_prev   <= 3'h1;
    end else begin
      sync_first  <= {link.serial_shift_clock_in, link.power_down_request,
                      link.conversion_start_n};
      sync_second <= sync_first;
      sync_prev   <= sync_second;
    end
  end

  logic start_n;
  logic pd;
  logic start_fall;
  logic pd_rise;
  logic shift_fall;

  assign start_n    = sync_second[0];
  assign pd         = sync_second[1];
  assign start_fall = sync_prev[0] & ~sync_second[0];
  assign pd_rise    = ~sync_prev[1] & sync_second[1];
  assign shift_fall = sync_prev[2] & ~sync_second[2];

  sar_link_pkg::conversion_start_n_state_type state;
  sar_link_pkg::conversion_start_n_state_type next_state;
  logic [TW-1:0]         timer;
  logic [TW-1:0]         next_timer;
  logic [IW-1:0]         bit_index;
  logic [IW-1:0]         next_bit_index;
  logic [RESOLUTION-1:0] approx;
  logic [RESOLUTION-1:0] next_approx;
  logic [RESOLUTION-1:0] shifter;
  logic [RESOLUTION-1:0] next_shifter;
  logic [RESOLUTION-1:0] next_result;
  logic                  next_result_valid;
  logic [RESOLUTION-1:0] next_trial_value;
  logic                  busy;
  logic                  next_busy;

  always_comb begin
    logic [RESOLUTION-1:0] decided;
    logic [RESOLUTION-1:0] prev_weight;
    decided           = approx | bit_weight(bit_index);
    prev_weight       = bit_weight(bit_index + 1'b1);
    next_state        = state;
    next_timer        = timer;
    next_bit_index    = bit_index;
    next_approx       = approx;
    next_shifter      = shifter;
    next_result       = result;
    next_result_valid = 1'b0;
    case (state)
      sar_link_pkg::conversion_start_n_idle: begin
        if (shift_fall) begin
          next_shifter = {shifter[RESOLUTION-2:0], 1'b0};
        end
        if ((start_fall && !pd) || (pd_rise && !start_n)) begin
          next_state     = sar_link_pkg::conversion_start_n_decide;
          next_timer     = '0;
          next_bit_index = TOP_INDEX;
          next_approx    = '0;
        end
      end
      sar_link_pkg::conversion_start_n_decide: begin
        next_timer = timer + 1'b1;
        if (timer == TW'(BIT_CYCLES - 1)) begin
          next_timer = '0;
          if (!comparator_high) begin
            next_approx = decided;
          end
          if (bit_index == '0) begin
            next_result       = comparator_high ? approx : decided;
            next_shifter      = comparator_high ? approx : decided;
            next_result_valid = 1'b1;
            next_state = pd ? sar_link_pkg::conversion_start_n_asleep : sar_link_pkg::conversion_start_n_idle;
          end else begin
            next_bit_index = bit_index - 1'b1;
            if (bit_index - 1'b1 == CORRECT_INDEX) begin
              next_state = sar_link_pkg::conversion_start_n_correct;
            end
          end
        end
      end
      sar_link_pkg::conversion_start_n_correct: begin
        // re-test the result so far; a wrong keep of the bit decided just before (bit 7) is backed out
        next_timer = timer + 1'b1;
        if (timer == TW'(CORRECT_CYCLES - 1)) begin
          next_timer = '0;
          next_state = sar_link_pkg::conversion_start_n_decide;
          if (comparator_high && approx >= prev_weight) begin
            next_approx = approx - prev_weight;
          end
        end
      end
      sar_link_pkg::conversion_start_n_asleep: begin
        if (!pd && start_n) begin
          next_state = sar_link_pkg::conversion_start_n_idle;
        end
      end
      default: begin
        next_state = sar_link_pkg::conversion_start_n_idle;
      end
    endcase
    case (next_state)
      sar_link_pkg::conversion_start_n_decide:  next_trial_value = next_approx | bit_weight(next_bit_index);
      sar_link_pkg::conversion_start_n_correct: next_trial_value = next_approx;
      default:                    next_trial_value = '0;
    endcase
    next_busy = (next_state == sar_link_pkg::conversion_start_n_decide) ||
                (next_state == sar_link_pkg::conversion_start_n_correct);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state         <= sar_link_pkg::conversion_start_n_idle;
      timer         <= '0;
      bit_index     <= '0;
      approx        <= '0;
      shifter       <= '0;
      result        <= '0;
      result_valid  <= 1'b0;
      trial_value   <= '0;
      busy          <= 1'b0;
      analog_enable <= 1'b1;
      reference_hiz <= 1'b0;
    end else begin
      state         <= next_state;
      timer         <= next_timer;
      bit_index     <= next_bit_index;
      approx        <= next_approx;
      shifter       <= next_shifter;
      result        <= next_result;
      result_valid  <= next_result_valid;
      trial_value   <= next_trial_value;
      busy          <= next_busy;
      analog_enable <= next_state != sar_link_pkg::conversion_start_n_asleep;
      reference_hiz <= pd;
    end
  end

  assign link.busy_n      = ~busy;
  assign link.serial_data = shifter[RESOLUTION-1];

endmodule : sar_converter_end

// ### verilog/sar_host_end.sv
/*
 * host end: drives conversion start, power-down and the shift clock in the
 * required orders, reads the result after busy rises, and times the settling.
 * assumes the converter end synchronises every pin it receives.
 */
`timescale 1ns/10ps
`include "sar_link_defs.svh"

module sar_host_end #(
  parameter int RESOLUTION    = `RESOLUTION_BITS,
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // link to the converter
  converter_link_if.host_end         link,
  // user requests
  input  wire logic                  convert_request,
  input  wire logic                  sleep_request,
  output logic                       ready,
  // results
  output logic      [RESOLUTION-1:0] data_word,
  output logic                       data_valid,
  output logic                       results_settled
);

  localparam int CW = 16;

  generate
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << CW) || RESOLUTION < 2 ||
        RESOLUTION > 32) begin : g_bad_params
      $error("sar_host_end: unsupported parameter values");
    end
  endgenerate

  function automatic logic at_count(input logic [CW-1:0] count, input int limit);
    at_count = count == CW'(limit - 1);
  endfunction : at_count

  logic [1:0] sync_first;
  logic [1:0] sync_second;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_first  <= 2'h1;
      sync_second <= 2'h1;
    end else begin
      sync_first  <= {link.serial_data, link.busy_n};
      sync_second <= sync_first;
    end
  end

  sar_link_pkg::host_state_type state;
  sar_link_pkg::host_state_type next_state;
  logic [CW-1:0]         count;
  logic [CW-1:0]         next_count;
  logic [4:0]            bits;
  logic [4:0]            next_bits;
  logic                  start_n;
  logic                  next_start_n;
  logic                  pd;
  logic                  next_pd;
  logic                  sclk;
  logic                  next_sclk;
  logic [RESOLUTION-1:0] next_data_word;
  logic                  next_data_valid;
  logic                  next_settled;

  always_comb begin
    next_state      = state;
    next_count      = count + 1'b1;
    next_bits       = bits;
    next_start_n    = start_n;
    next_pd         = pd;
    next_sclk       = sclk;
    next_data_word  = data_word;
    next_data_valid = 1'b0;
    next_settled    = results_settled;
    case (state)
      sar_link_pkg::host_idle: begin
        next_count = '0;
        if (sleep_request) begin
          next_start_n = 1'b0;
          next_state   = sar_link_pkg::host_sleep_entry;
        end else if (convert_request) begin
          next_start_n = 1'b0;
          next_state   = sar_link_pkg::host_start;
        end
      end
      sar_link_pkg::host_start: begin
        if (at_count(count, `START_LOW_CYCLES)) begin
          next_start_n = 1'b1;
          next_state   = sar_link_pkg::host_wait;
        end
      end
      sar_link_pkg::host_wait: begin
        // nothing moves until busy returns high
        if (sync_second[0]) begin
          next_count = '0;
          next_bits  = '0;
          next_sclk  = 1'b1;
          next_state = sar_link_pkg::host_shift_high;
        end
      end
      sar_link_pkg::host_shift_high: begin
        if (at_count(count, `SHIFT_HALF_CYCLES)) begin
          next_count     = '0;
          next_data_word = {data_word[RESOLUTION-2:0], sync_second[1]};
          next_sclk      = 1'b0;
          next_state     = sar_link_pkg::host_shift_low;
        end
      end
      sar_link_pkg::host_shift_low: begin
        if (at_count(count, `SHIFT_HALF_CYCLES)) begin
          next_count = '0;
          if (bits == 5'(RESOLUTION - 1)) begin
            next_data_valid = 1'b1;
            next_state      = sar_link_pkg::host_idle;
          end else begin
            next_bits  = bits + 1'b1;
            next_sclk  = 1'b1;
            next_state = sar_link_pkg::host_shift_high;
          end
        end
      end
      sar_link_pkg::host_sleep_entry: begin
        if (at_count(count, `STEP_CYCLES)) begin
          next_count   = '0;
          next_pd      = 1'b1;
          next_settled = 1'b0;
          next_state   = sar_link_pkg::host_asleep;
        end
      end
      sar_link_pkg::host_asleep: begin
        // the conversion started on entry runs out before any pin moves
        if (count >= CW'(`STEP_CYCLES)) begin
          next_count = count;
          if (!sleep_request && sync_second[0]) begin
            next_count   = '0;
            next_start_n = 1'b1;
            next_state   = sar_link_pkg::host_wake_step;
          end
        end
      end
      sar_link_pkg::host_wake_step: begin
        if (at_count(count, `STEP_CYCLES)) begin
          next_count = '0;
          next_pd    = 1'b0;
          next_state = sar_link_pkg::host_settle;
        end
      end
      sar_link_pkg::host_settle: begin
        if (at_count(count, SETTLE_CYCLES)) begin
          next_count   = '0;
          next_settled = 1'b1;
          next_state   = sar_link_pkg::host_idle;
        end
      end
      default: begin
        next_state = sar_link_pkg::host_idle;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state           <= sar_link_pkg::host_idle;
      count           <= '0;
      bits            <= '0;
      start_n         <= 1'b1;
      pd              <= 1'b0;
      sclk            <= 1'b0;
      data_word       <= '0;
      data_valid      <= 1'b0;
      results_settled <= 1'b1;
    end else begin
      state           <= next_state;
      count           <= next_count;
      bits            <= next_bits;
      start_n         <= next_start_n;
      pd              <= next_pd;
      sclk            <= next_sclk;
      data_word       <= next_data_word;
      data_valid      <= next_data_valid;
      results_settled <= next_settled;
    end
  end

  assign ready                      = state == sar_link_pkg::host_idle;
  assign link.conversion_start_n    = start_n;
  assign link.power_down_request    = pd;
  assign link.serial_shift_clock_in = sclk;

endmodule : sar_host_end

// ### tb/sar_link_asserts.sv
/*
 * timing relations on the pins of the link between host end and converter end.
 * assumes both ends are design modules clocked by sys_clk and reset by rst.
 */
`timescale 1ns/10ps

module sar_link_asserts #(
  parameter int CONVERSION_START_N_CYCLES = 330
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // link pins
  input wire logic conversion_start_n,
  input wire logic power_down_request,
  input wire logic serial_shift_clock_in,
  input wire logic busy_n,
  input wire logic serial_data
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  logic [9:0] low_cycles;
  logic [4:0] shifts;

  // length of the running conversion and shift clocks since it ended
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_cycles <= 10'h000;
      shifts     <= 5'h00;
    end else begin
      low_cycles <= busy_n ? 10'h000 : low_cycles + 10'h001;
      shifts     <= !busy_n ? 5'h00 : shifts + {4'h0, $rose(serial_shift_clock_in)};
    end
  end

  sequence s_start;
    $fell(conversion_start_n) && !power_down_request && busy_n;
  endsequence
  sequence s_wake;
    $fell(power_down_request) ##0 conversion_start_n;
  endsequence

  property p_start_answer;
    s_start |-> ##[3:5] !busy_n;
  endproperty
  property p_conversion_start_n_length;
    $rose(busy_n) |-> low_cycles == CONVERSION_START_N_CYCLES;
  endproperty
  property p_conversion_start_n_bound;
    !busy_n |-> low_cycles < CONVERSION_START_N_CYCLES;
  endproperty
  property p_start_release;
    $fell(conversion_start_n) |-> ##[1:25] (conversion_start_n || power_down_request);
  endproperty
  property p_quiet;
    (!busy_n && low_cycles >= 10'h0a0) |-> $stable(conversion_start_n) &&
      $stable(power_down_request) && $stable(serial_shift_clock_in);
  endproperty
  property p_no_clock_busy;
    !busy_n |-> !serial_shift_clock_in;
  endproperty
  property p_sleep_entry;
    $rose(power_down_request) |-> !conversion_start_n && !$past(conversion_start_n, 8);
  endproperty
  property p_exit_order;
    $fell(power_down_request) |-> conversion_start_n && $past(conversion_start_n, 8);
  endproperty
  property p_asleep_idle;
    (conversion_start_n && power_down_request) |-> busy_n;
  endproperty
  property p_wake_idle;
    s_wake |-> busy_n[*6];
  endproperty
  property p_shift_count;
    shifts <= 5'h10;
  endproperty
  property p_data_hold;
    (serial_shift_clock_in && $past(serial_shift_clock_in)) |-> $stable(serial_data);
  endproperty

  a_start_answer:  assert property (p_start_answer)  else $error("busy did not follow start");
  a_conversion_start_n_length:   assert property (p_conversion_start_n_length)   else $error("conversion length wrong");
  a_conversion_start_n_bound:    assert property (p_conversion_start_n_bound)    else $error("conversion ran too long");
  a_start_release: assert property (p_start_release) else $error("start held low too long");
  a_quiet:         assert property (p_quiet)         else $error("pin moved in quiet time");
  a_no_clock_busy: assert property (p_no_clock_busy) else $error("shift clock while busy");
  a_sleep_entry:   assert property (p_sleep_entry)   else $error("sleep entry order wrong");
  a_exit_order:    assert property (p_exit_order)    else $error("sleep exit order wrong");
  a_asleep_idle:   assert property (p_asleep_idle)   else $error("busy while asleep");
  a_wake_idle:     assert property (p_wake_idle)     else $error("conversion on wake");
  a_shift_count:   assert property (p_shift_count)   else $error("too many shift clocks");
  a_data_hold:     assert property (p_data_hold)     else $error("data moved while clock high");
endmodule : sar_link_asserts

// ### tb/sar_powerdown_conversion_start_n_control_bench.sv
/*
 * bench: host end and converter end joined on one link; a second converter
 * driven pin by pin from the bench for wrong orders.
 * assumes an ideal comparator that answers from trial_value at once.
 */
`timescale 1ns/10ps

module sar_powerdown_conversion_start_n_control_bench;
  logic        sys_clk;
  logic        rst;
  logic        convert_request;
  logic        sleep_request;
  logic        ready;
  logic [15:0] data_word;
  logic        data_valid;
  logic        results_settled;
  logic [15:0] target_a, target_b, trial_a, trial_b, result_a, result_b;
  logic        ae_a, hiz_a, ae_b, hiz_b, lie_on, lie_keep, rv_a;
  logic        cmp_a, cmp_b;
  int          bad_count;
  int          compares;
  logic [15:0] codes [6] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff, 16'ha5c3, 16'h0001};

  converter_link_if link_a ();
  converter_link_if link_b ();

  // comparator; optionally wrong on bit 3, or forced low so that a bit is kept
  assign cmp_a = ((trial_a > target_a) || (lie_on && trial_a[3] && trial_a[2:0] == 3'h0)) &&
                 !lie_keep;
  assign cmp_b = trial_b > target_b;

  sar_converter_end i_sar_converter_end (.sys_clk(sys_clk), .rst(rst), .link(link_a),
    .comparator_high(cmp_a), .trial_value(trial_a), .analog_enable(ae_a),
    .reference_hiz(hiz_a), .result(result_a), .result_valid(rv_a));
  sar_converter_end i_sar_converter_end_2 (.sys_clk(sys_clk), .rst(rst), .link(link_b),
    .comparator_high(cmp_b), .trial_value(trial_b), .analog_enable(ae_b),
    .reference_hiz(hiz_b), .result(result_b), .result_valid());
  sar_host_end #(.SETTLE_CYCLES(50)) i_sar_host_end (.sys_clk(sys_clk), .rst(rst),
    .link(link_a), .convert_request(convert_request), .sleep_request(sleep_request),
    .ready(ready), .data_word(data_word), .data_valid(data_valid),
    .results_settled(results_settled));
  sar_link_asserts #(.CONVERSION_START_N_CYCLES(16 * 20 + 10)) i_sar_link_asserts (.sys_clk(sys_clk),
    .rst(rst), .conversion_start_n(link_a.conversion_start_n),
    .power_down_request(link_a.power_down_request),
    .serial_shift_clock_in(link_a.serial_shift_clock_in),
    .busy_n(link_a.busy_n), .serial_data(link_a.serial_data));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic check_word(input logic [15:0] act, input logic [15:0] exp);
    compares++;
    if (act !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic act, input logic exp);
    check_word({15'h0000, act}, {15'h0000, exp});
  endtask : check_bit

  function automatic logic probe(input int sel);
    case (sel)
      0: return data_valid;
      1: return ready;
      2: return link_a.busy_n;
      3: return link_a.power_down_request;
      4: return link_b.busy_n;
      5: return ae_b;
      default: return rv_a;
    endcase
  endfunction : probe

  // bounded wait for a level, sampled between clock edges
  task automatic wait_for(input int sel, input logic lvl);
    int n;
    n = 0;
    while (probe(sel) !== lvl && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    check_bit(probe(sel), lvl);
  endtask : wait_for

  task automatic convert(input logic [15:0] tgt, input logic [15:0] exp);
    target_a = tgt;
    wait_for(1, 1'b1);
    convert_request = 1'b1;
    @(negedge sys_clk);
    convert_request = 1'b0;
    wait_for(2, 1'b0);
    check_word(trial_a, 16'h8000);
    wait_for(6, 1'b1);
    check_word(result_a, exp);
    wait_for(0, 1'b1);
    check_word(data_word, exp);
  endtask : convert

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (30000) @(posedge sys_clk);
    bad_count++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    convert_request = 1'b0;
    sleep_request = 1'b0;
    lie_on = 1'b0;
    lie_keep = 1'b0;
    target_a = 16'h0000;
    target_b = 16'h3c5a;
    link_b.conversion_start_n = 1'b1;
    link_b.power_down_request = 1'b0;
    link_b.serial_shift_clock_in = 1'b0;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    check_bit(ae_a, 1'b1);
    check_bit(hiz_a, 1'b0);
    foreach (codes[k]) convert(codes[k], codes[k]);
    lie_on = 1'b1;
    convert(16'h00f8, 16'h00f7);
    lie_on = 1'b0;
    // a wrong keep of bit 7 must be backed out by the correction step
    fork
      convert(16'h0070, 16'h0070);
      begin
        @(negedge link_a.busy_n);
        repeat (175) @(negedge sys_clk);
        lie_keep = 1'b1;
        repeat (7) @(negedge sys_clk);
        lie_keep = 1'b0;
      end
    join
    // sleep through the host end, then wake
    sleep_request = 1'b1;
    wait_for(3, 1'b1);
    repeat (5) @(negedge sys_clk);
    check_bit(hiz_a, 1'b1);
    check_bit(results_settled, 1'b0);
    wait_for(2, 1'b1);
    repeat (5) @(negedge sys_clk);
    check_bit(ae_a, 1'b0);
    sleep_request = 1'b0;
    wait_for(3, 1'b0);
    check_bit(results_settled, 1'b0);
    wait_for(1, 1'b1);
    check_bit(results_settled, 1'b1);
    check_bit(ae_a, 1'b1);
    convert(16'h1234, 16'h1234);
    // second converter: wrong orders driven pin by pin
    link_b.power_down_request = 1'b1;
    repeat (20) @(negedge sys_clk);
    check_bit(link_b.busy_n, 1'b1);
    check_bit(ae_b, 1'b1);
    link_b.power_down_request = 1'b0;
    repeat (5) @(negedge sys_clk);
    link_b.conversion_start_n = 1'b0;
    wait_for(4, 1'b0);
    wait_for(4, 1'b1);
    check_word(result_b, target_b);
    link_b.power_down_request = 1'b1;
    repeat (8) @(negedge sys_clk);
    check_bit(link_b.busy_n, 1'b0);
    wait_for(4, 1'b1);
    repeat (5) @(negedge sys_clk);
    check_bit(ae_b, 1'b0);
    check_bit(hiz_b, 1'b1);
    // a fresh start edge while asleep must not convert
    link_b.conversion_start_n = 1'b1;
    repeat (5) @(negedge sys_clk);
    link_b.conversion_start_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    check_bit(link_b.busy_n, 1'b1);
    check_bit(ae_b, 1'b0);
    link_b.power_down_request = 1'b0;
    repeat (10) @(negedge sys_clk);
    check_bit(ae_b, 1'b0);
    link_b.conversion_start_n = 1'b1;
    wait_for(5, 1'b1);
    repeat (10) @(negedge sys_clk);
    check_bit(link_b.busy_n, 1'b1);
    give_verdict();
  end
endmodule : sar_powerdown_conversion_start_n_control_bench
